//--- hw/jtag_instruction_unit.sv
`timescale 1ns/1ps
module jtag_instruction_unit #(
    parameter int PIN_COUNT = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic tck_i,
    input wire logic trst_n_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic tms_driven_i,
    input wire logic tdi_driven_i,
    input wire logic trst_driven_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    input wire logic [PIN_COUNT-1:0] core_out_i,
    input wire logic [PIN_COUNT-1:0] core_oe_i,
    input wire logic [PIN_COUNT-1:0] pin_in_i,
    output logic [PIN_COUNT-1:0] pin_out_o,
    output logic [PIN_COUNT-1:0] pin_oe_o,
    output logic [PIN_COUNT-1:0] core_in_o,
    input wire logic stop_request_i,
    output logic stop_allowed_o,
    output logic system_reset_o,
    output logic [3:0] active_instr_o
);
    jtag_unit_pkg::tap_state_e tap_state;
    logic [3:0] ir_shift;
    logic [3:0] ir_latch;
    logic bypass_bit;
    logic [jtag_unit_pkg::BSR_LENGTH-1:0] bsr_shift;
    logic [jtag_unit_pkg::BSR_LENGTH-1:0] bsr_update;
    jtag_unit_pkg::instr_decode_s dec;
    jtag_unit_pkg::tap_pins_s pins;
    logic tdo_next;
    logic tlr_tck;
    logic tlr_sys;
    logic extest_sys;

    ////////////////////////////////////////////////////////////////////////////
    // Pull-ups: an undriven pin reads as one
    assign pins.tms = tms_driven_i ? tms_i : 1'b1;
    assign pins.tdi = tdi_driven_i ? tdi_i : 1'b1;
    assign pins.trst_n = trst_driven_i ? trst_n_i : 1'b1;

    tap_fsm u_tap (
        .tck_i(tck_i),
        .trst_n_i(pins.trst_n),
        .tms_i(pins.tms),
        .state_o(tap_state)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Instruction register
    always_ff @(posedge tck_i or negedge pins.trst_n) begin
        if (!pins.trst_n) begin
            ir_shift <= jtag_unit_pkg::IR_RESET_VALUE;
        end else if (tap_state == jtag_unit_pkg::TAP_CAP_IR) begin
            ir_shift <= jtag_unit_pkg::IR_CLAMP;
        end else if (tap_state == jtag_unit_pkg::TAP_SHIFT_IR) begin
            ir_shift <= {pins.tdi, ir_shift[3:1]};
        end
    end

    // Latches update on the falling edge so the new code is steady at the next rise
    always_ff @(negedge tck_i or negedge pins.trst_n) begin
        if (!pins.trst_n) begin
            ir_latch <= jtag_unit_pkg::IR_RESET_VALUE;
        end else if (tap_state == jtag_unit_pkg::TAP_RESET) begin
            ir_latch <= jtag_unit_pkg::IR_RESET_VALUE;
        end else if (tap_state == jtag_unit_pkg::TAP_UPD_IR) begin
            ir_latch <= ir_shift;
        end
    end

    assign active_instr_o = ir_latch;

    always_comb begin
        dec = '0;
        if (ir_latch == jtag_unit_pkg::IR_EXTEST) begin
            dec.extest = 1'b1;
        end else if (ir_latch == jtag_unit_pkg::IR_SAMPLE) begin
            dec.sample = 1'b1;
        end else if (ir_latch == jtag_unit_pkg::IR_HIZ) begin
            dec.hiz = 1'b1;
            dec.bypass_sel = 1'b1;
        end else if (ir_latch == jtag_unit_pkg::IR_CLAMP) begin
            dec.clamp = 1'b1;
            dec.bypass_sel = 1'b1;
        end else begin
            // Covers 0x1x and every unlisted code
            dec.bypass_sel = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data registers
    always_ff @(posedge tck_i or negedge pins.trst_n) begin
        if (!pins.trst_n) begin
            bypass_bit <= 1'b0;
        end else if (dec.bypass_sel && tap_state == jtag_unit_pkg::TAP_CAP_DR) begin
            bypass_bit <= 1'b0;
        end else if (dec.bypass_sel && tap_state == jtag_unit_pkg::TAP_SHIFT_DR) begin
            bypass_bit <= pins.tdi;
        end
    end

    // Cells alternate data and output-enable; low cells map onto the pins
    always_ff @(posedge tck_i or negedge pins.trst_n) begin
        if (!pins.trst_n) begin
            bsr_shift <= '0;
        end else if (!dec.bypass_sel && tap_state == jtag_unit_pkg::TAP_CAP_DR) begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                bsr_shift[2*i] <= dec.extest ? pin_in_i[i] : core_out_i[i];
                bsr_shift[2*i+1] <= core_oe_i[i];
            end
        end else if (!dec.bypass_sel && tap_state == jtag_unit_pkg::TAP_SHIFT_DR) begin
            bsr_shift <= {pins.tdi, bsr_shift[jtag_unit_pkg::BSR_LENGTH-1:1]};
        end
    end

    always_ff @(negedge tck_i or negedge pins.trst_n) begin
        if (!pins.trst_n) begin
            bsr_update <= '0;
        end else if (!dec.bypass_sel && tap_state == jtag_unit_pkg::TAP_UPD_DR) begin
            bsr_update <= bsr_shift;
        end
    end

    always_comb begin
        if (tap_state == jtag_unit_pkg::TAP_SHIFT_IR) begin
            tdo_next = ir_shift[0];
        end else if (dec.bypass_sel) begin
            tdo_next = bypass_bit;
        end else begin
            tdo_next = bsr_shift[0];
        end
    end

    // TDO changes on the falling edge, as the tester samples it on the rise
    always_ff @(negedge tck_i or negedge pins.trst_n) begin
        if (!pins.trst_n) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else begin
            tdo_o <= tdo_next;
            tdo_oe_o <= (tap_state == jtag_unit_pkg::TAP_SHIFT_IR) ||
                        (tap_state == jtag_unit_pkg::TAP_SHIFT_DR);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin muxing; combinational so the core keeps full pin timing
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_pin
            always_comb begin
                if (dec.hiz) begin
                    pin_out_o[g] = 1'b0;
                    pin_oe_o[g] = 1'b0;
                end else if (dec.extest || dec.clamp) begin
                    pin_out_o[g] = bsr_update[2*g];
                    pin_oe_o[g] = bsr_update[2*g+1];
                end else begin
                    pin_out_o[g] = core_out_i[g];
                    pin_oe_o[g] = core_oe_i[g];
                end
                core_in_o[g] = pin_in_i[g];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Crossings into the system domain; TCK may stop, so levels only
    assign tlr_tck = (tap_state == jtag_unit_pkg::TAP_RESET);

    level_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_i(clk_sys_i),
        .rst_i(rst_i),
        .async_i({tlr_tck, dec.extest}),
        .sync_o({tlr_sys, extest_sys})
    );

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            stop_allowed_o <= 1'b0;
        end else begin
            stop_allowed_o <= stop_request_i && tlr_sys;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            system_reset_o <= 1'b0;
        end else begin
            system_reset_o <= extest_sys;
        end
    end

endmodule

//--- hw/jtag_unit_pkg.sv
package jtag_unit_pkg;

    localparam int IR_WIDTH = 4;
    localparam int BSR_LENGTH = 316;

    // Instruction codes written as {B3,B2,B1,B0}; B0 is the first bit shifted
    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_SAMPLE = 4'h1;
    localparam logic [3:0] IR_HIZ = 4'h4;
    localparam logic [3:0] IR_CLAMP = 4'h5;
    localparam logic [3:0] IR_RESET_VALUE = 4'hF;
    localparam logic [3:0] IR_BYPASS_MASK = 4'hA;
    localparam logic [3:0] IR_BYPASS_MATCH = 4'h2;

    localparam int TLR_TMS_HIGH_COUNT = 5;
    localparam int SYNC_STAGES = 3;

    typedef enum logic [15:0] {
        TAP_RESET = 16'h0001,
        TAP_IDLE = 16'h0002,
        TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008,
        TAP_SHIFT_DR = 16'h0010,
        TAP_EXIT1_DR = 16'h0020,
        TAP_PAUSE_DR = 16'h0040,
        TAP_EXIT2_DR = 16'h0080,
        TAP_UPD_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200,
        TAP_CAP_IR = 16'h0400,
        TAP_SHIFT_IR = 16'h0800,
        TAP_EXIT1_IR = 16'h1000,
        TAP_PAUSE_IR = 16'h2000,
        TAP_EXIT2_IR = 16'h4000,
        TAP_UPD_IR = 16'h8000
    } tap_state_e;

    typedef struct packed {
        logic extest;
        logic sample;
        logic bypass_sel;
        logic hiz;
        logic clamp;
    } instr_decode_s;

    typedef struct packed {
        logic tdi;
        logic tms;
        logic trst_n;
    } tap_pins_s;

endpackage

//--- hw/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A change is accepted only once the second and third stages agree
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_o <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    sync_o[i] <= stage3[i];
                end
            end
        end
    end

endmodule

//--- hw/tap_fsm.sv
`timescale 1ns/1ps
module tap_fsm (
    input wire logic tck_i,
    input wire logic trst_n_i,
    input wire logic tms_i,
    output jtag_unit_pkg::tap_state_e state_o
);
    jtag_unit_pkg::tap_state_e state;
    jtag_unit_pkg::tap_state_e next_state;

    assign state_o = state;

    // Held TMS high walks every state to reset within five edges
    always_comb begin
        case (state)
            jtag_unit_pkg::TAP_RESET: next_state = tms_i ? jtag_unit_pkg::TAP_RESET
                                                         : jtag_unit_pkg::TAP_IDLE;
            jtag_unit_pkg::TAP_IDLE: next_state = tms_i ? jtag_unit_pkg::TAP_SEL_DR
                                                        : jtag_unit_pkg::TAP_IDLE;
            jtag_unit_pkg::TAP_SEL_DR: next_state = tms_i ? jtag_unit_pkg::TAP_SEL_IR
                                                          : jtag_unit_pkg::TAP_CAP_DR;
            jtag_unit_pkg::TAP_CAP_DR: next_state = tms_i ? jtag_unit_pkg::TAP_EXIT1_DR
                                                          : jtag_unit_pkg::TAP_SHIFT_DR;
            jtag_unit_pkg::TAP_SHIFT_DR: next_state = tms_i ? jtag_unit_pkg::TAP_EXIT1_DR
                                                            : jtag_unit_pkg::TAP_SHIFT_DR;
            jtag_unit_pkg::TAP_EXIT1_DR: next_state = tms_i ? jtag_unit_pkg::TAP_UPD_DR
                                                            : jtag_unit_pkg::TAP_PAUSE_DR;
            jtag_unit_pkg::TAP_PAUSE_DR: next_state = tms_i ? jtag_unit_pkg::TAP_EXIT2_DR
                                                            : jtag_unit_pkg::TAP_PAUSE_DR;
            jtag_unit_pkg::TAP_EXIT2_DR: next_state = tms_i ? jtag_unit_pkg::TAP_UPD_DR
                                                            : jtag_unit_pkg::TAP_SHIFT_DR;
            jtag_unit_pkg::TAP_UPD_DR: next_state = tms_i ? jtag_unit_pkg::TAP_SEL_DR
                                                          : jtag_unit_pkg::TAP_IDLE;
            jtag_unit_pkg::TAP_SEL_IR: next_state = tms_i ? jtag_unit_pkg::TAP_RESET
                                                          : jtag_unit_pkg::TAP_CAP_IR;
            jtag_unit_pkg::TAP_CAP_IR: next_state = tms_i ? jtag_unit_pkg::TAP_EXIT1_IR
                                                          : jtag_unit_pkg::TAP_SHIFT_IR;
            jtag_unit_pkg::TAP_SHIFT_IR: next_state = tms_i ? jtag_unit_pkg::TAP_EXIT1_IR
                                                            : jtag_unit_pkg::TAP_SHIFT_IR;
            jtag_unit_pkg::TAP_EXIT1_IR: next_state = tms_i ? jtag_unit_pkg::TAP_UPD_IR
                                                            : jtag_unit_pkg::TAP_PAUSE_IR;
            jtag_unit_pkg::TAP_PAUSE_IR: next_state = tms_i ? jtag_unit_pkg::TAP_EXIT2_IR
                                                            : jtag_unit_pkg::TAP_PAUSE_IR;
            jtag_unit_pkg::TAP_EXIT2_IR: next_state = tms_i ? jtag_unit_pkg::TAP_UPD_IR
                                                            : jtag_unit_pkg::TAP_SHIFT_IR;
            jtag_unit_pkg::TAP_UPD_IR: next_state = tms_i ? jtag_unit_pkg::TAP_SEL_DR
                                                          : jtag_unit_pkg::TAP_IDLE;
            default: next_state = jtag_unit_pkg::TAP_RESET;
        endcase
    end

    always_ff @(posedge tck_i or negedge trst_n_i) begin
        if (!trst_n_i) begin
            state <= jtag_unit_pkg::TAP_RESET;
        end else begin
            state <= next_state;
        end
    end

endmodule

//--- testbench/jtag_instruction_unit_properties.sv
`timescale 1ns/1ps
module jtag_instruction_unit_properties #(
    parameter int PIN_COUNT = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic tck_i,
    input wire logic trst_n_i,
    input wire logic trst_driven_i,
    input wire logic tms_i,
    input wire logic tms_driven_i,
    input wire logic [PIN_COUNT-1:0] core_out_i,
    input wire logic [PIN_COUNT-1:0] core_oe_i,
    input wire logic [PIN_COUNT-1:0] pin_in_i,
    input wire logic [PIN_COUNT-1:0] pin_out_o,
    input wire logic [PIN_COUNT-1:0] pin_oe_o,
    input wire logic [PIN_COUNT-1:0] core_in_o,
    input wire logic stop_request_i,
    input wire logic stop_allowed_o,
    input wire logic system_reset_o,
    input wire logic [3:0] active_instr_o
);
    // An undriven mode pin reads high through its pull-up
    wire tms_eff = tms_i | ~tms_driven_i;
    wire trst_eff = trst_n_i | ~trst_driven_i;
    property p_ir_tlr;
        @(posedge tck_i) disable iff (!trst_n_i)
        tms_eff[*7] |-> active_instr_o == jtag_unit_pkg::IR_RESET_VALUE;
    endproperty
    a_ir_tlr: assert property (p_ir_tlr)
    else $error("instruction not preset in reset state");
    // Reaching update-IR needs a high mode bit, so three low ones freeze the latches
    property p_ir_hold;
        @(posedge tck_i) disable iff (!trst_n_i) (!tms_eff)[*3] |-> $stable(active_instr_o);
    endproperty
    a_ir_hold: assert property (p_ir_hold)
    else $error("instruction changed outside update");
    property p_trst_ir;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!trst_eff)[*2] |-> active_instr_o == jtag_unit_pkg::IR_RESET_VALUE;
    endproperty
    a_trst_ir: assert property (p_trst_ir)
    else $error("test reset did not preset instruction");
    property p_hiz;
        @(posedge clk_sys_i) disable iff (rst_i || !trst_n_i)
        active_instr_o == jtag_unit_pkg::IR_HIZ |-> pin_oe_o == '0;
    endproperty
    a_hiz: assert property (p_hiz)
    else $error("driver enabled in high impedance mode");
    property p_extest_rst;
        @(posedge tck_i) disable iff (!trst_n_i)
        (active_instr_o == jtag_unit_pkg::IR_EXTEST)[*2] |-> system_reset_o;
    endproperty
    a_extest_rst: assert property (p_extest_rst)
    else $error("system logic not held in external test");
    property p_sample;
        @(posedge clk_sys_i) disable iff (rst_i || !trst_n_i)
        active_instr_o == jtag_unit_pkg::IR_SAMPLE |->
        pin_out_o == core_out_i && pin_oe_o == core_oe_i && core_in_o == pin_in_i;
    endproperty
    a_sample: assert property (p_sample)
    else $error("sampling disturbed system signals");
    property p_clamp;
        @(posedge clk_sys_i) disable iff (rst_i || !trst_n_i)
        active_instr_o == jtag_unit_pkg::IR_CLAMP && $stable(active_instr_o)
        |-> $stable(pin_out_o) && $stable(pin_oe_o);
    endproperty
    a_clamp: assert property (p_clamp)
    else $error("clamped pins moved");
    property p_stop_ok;
        @(posedge tck_i) disable iff (!trst_n_i || rst_i)
        (tms_eff && stop_request_i)[*7] |-> stop_allowed_o;
    endproperty
    a_stop_ok: assert property (p_stop_ok)
    else $error("stop refused in reset state");
    property p_stop_block;
        @(posedge tck_i) disable iff (!trst_n_i || rst_i) (!tms_eff)[*3] |-> !stop_allowed_o;
    endproperty
    a_stop_block: assert property (p_stop_block)
    else $error("stop allowed outside reset state");
    c_extest: cover property (@(posedge tck_i) active_instr_o == jtag_unit_pkg::IR_EXTEST);
    c_clamp: cover property (@(posedge tck_i) active_instr_o == jtag_unit_pkg::IR_CLAMP);
    c_hiz: cover property (@(posedge tck_i) active_instr_o == jtag_unit_pkg::IR_HIZ);
endmodule
bind jtag_instruction_unit jtag_instruction_unit_properties #(.PIN_COUNT(PIN_COUNT)) chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .tck_i(tck_i), .trst_n_i(trst_n_i),
    .trst_driven_i(trst_driven_i),
    .tms_i(tms_i), .tms_driven_i(tms_driven_i), .core_out_i(core_out_i),
    .core_oe_i(core_oe_i), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .core_in_o(core_in_o), .stop_request_i(stop_request_i),
    .stop_allowed_o(stop_allowed_o), .system_reset_o(system_reset_o),
    .active_instr_o(active_instr_o));

//--- testbench/jtag_instruction_unit_tb.sv
`timescale 1ns/1ps
module jtag_instruction_unit_tb;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic tck, tms, tdi, trst_n, tdo, tdo_oe, stop_ok, sys_rst, b;
    logic tms_driven = 1'b1;
    logic stop_req = 1'b0;
    logic tdi_driven = 1'b1;
    logic trst_driven = 1'b1;
    logic freeze = 1'b0;
    logic [7:0] core_out = 8'h00, core_oe = 8'h00, pin_in = 8'h00;
    logic [7:0] pin_out, pin_oe, core_in, d, e;
    logic [3:0] instr;
    logic [15:0] exp_q[$], obs_q[$];
    logic [331:0] din, dout;
    int fail_count = 0;
    int total_checks = 0;
    int unsigned seed;
    jtag_tester_model tm (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
        .tdo_i(tdo_oe ? tdo : ~tdo));
    jtag_instruction_unit #(.PIN_COUNT(8)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .tck_i(tck), .trst_n_i(trst_n), .tms_i(tms),
        .tdi_i(tdi), .tms_driven_i(tms_driven), .tdi_driven_i(tdi_driven),
        .trst_driven_i(trst_driven), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .core_out_i(core_out),
        .core_oe_i(core_oe), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .core_in_o(core_in), .stop_request_i(stop_req), .stop_allowed_o(stop_ok),
        .system_reset_o(sys_rst), .active_instr_o(instr));
    ////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // Frozen while boundary cells capture, since the two clocks are unrelated
    always @(posedge clk_sys_i) begin
        if (!freeze) begin
            core_out <= 8'($urandom);
            core_oe <= 8'($urandom);
            pin_in <= 8'($urandom);
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] cells(input logic [7:0] dat, input logic [7:0] en);
        logic [15:0] r;
        for (int i = 0; i < 8; i++) r[2*i +: 2] = {en[i], dat[i]};
        return r;
    endfunction
    task automatic note(input logic [15:0] exp, input logic [15:0] seen);
        exp_q.push_back(exp);
        obs_q.push_back(seen);
    endtask
    always @(posedge clk_sys_i) begin
        if (obs_q.size() > 0) check(obs_q.pop_front(), exp_q.pop_front());
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic load_ir(input logic [3:0] c);
        tm.scan(1'b1, 4, 332'(c), dout);
        note(16'(jtag_unit_pkg::IR_CLAMP), dout[3:0]);
        note(16'(c), instr);
    endtask
    // One bypass bit: a zero first, then the input delayed by one
    task automatic bypass_check();
        logic [3:0] v;
        v = 4'($urandom);
        tm.scan(1'b0, 4, 332'(v), dout);
        note({v[2:0], 1'b0}, dout[3:0]);
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        fail_count++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        seed = $urandom(18);
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        tm.set_trst(1'b1);
        tm.tlr();
        note(16'h000F, instr);
        load_ir(jtag_unit_pkg::IR_SAMPLE);
        @(negedge clk_sys_i);
        note({core_out, core_oe}, {pin_out, pin_oe});
        note(16'(pin_in), 16'(core_in));
        @(posedge clk_sys_i);
        freeze <= 1'b1;
        $display("test capture and sample done");
        d = 8'($urandom);
        e = 8'($urandom);
        din = '0;
        din[7:0] = 8'($urandom);
        for (int i = 0; i < 8; i++) din[8+2*i +: 2] = {e[i], d[i]};
        tm.scan(1'b0, jtag_unit_pkg::BSR_LENGTH + 8, din, dout);
        note(cells(core_out, core_oe), dout[15:0]);
        note(din[7:0], dout[jtag_unit_pkg::BSR_LENGTH +: 8]);
        load_ir(jtag_unit_pkg::IR_EXTEST);
        repeat (4) @(negedge clk_sys_i);
        note({d, e}, {pin_out, pin_oe});
        note(16'h0001, sys_rst);
        tm.scan(1'b0, jtag_unit_pkg::BSR_LENGTH + 8, din, dout);
        note(cells(pin_in, core_oe), dout[15:0]);
        note({d, e}, {pin_out, pin_oe});
        @(posedge clk_sys_i);
        freeze <= 1'b0;
        $display("test preload and external done");
        load_ir(jtag_unit_pkg::IR_CLAMP);
        bypass_check();
        note({d, e}, {pin_out, pin_oe});
        load_ir(jtag_unit_pkg::IR_HIZ);
        bypass_check();
        note(16'h0000, pin_oe);
        $display("test clamp and high impedance done");
        for (int c = 2; c < 16; c++) begin
            if (c == 4 || c == 5) continue;
            load_ir(4'(c));
            bypass_check();
        end
        $display("test bypass codes done");
        load_ir(jtag_unit_pkg::IR_EXTEST);
        @(posedge clk_sys_i);
        tms_driven <= 1'b0;
        stop_req <= 1'b1;
        repeat (8) tm.step(1'b0, ~tm.tdi_o, b);
        note(16'h000F, instr);
        note(16'h0001, stop_ok);
        @(posedge clk_sys_i);
        tms_driven <= 1'b1;
        repeat (3) tm.step(1'b0, ~tm.tdi_o, b);
        @(negedge clk_sys_i);
        note(16'h0000, stop_ok);
        @(posedge clk_sys_i);
        tdi_driven <= 1'b0;
        tm.scan(1'b0, 4, '0, dout);
        note(16'h000E, dout[3:0]);
        @(posedge clk_sys_i);
        tdi_driven <= 1'b1;
        tm.step(1'b1, 1'b0, b);
        repeat (3) tm.step(1'b0, 1'b0, b);
        note(16'h0001, tdo_oe);
        repeat (2) tm.step(1'b1, 1'b0, b);
        tm.step(1'b0, 1'b0, b);
        note(16'h0000, tdo_oe);
        $display("test pull-up and stop done");
        load_ir(jtag_unit_pkg::IR_EXTEST);
        @(posedge clk_sys_i);
        trst_driven <= 1'b0;
        @(negedge clk_sys_i);
        tm.set_trst(1'b0);
        repeat (2) @(negedge clk_sys_i);
        note(16'(jtag_unit_pkg::IR_EXTEST), instr);
        @(posedge clk_sys_i);
        trst_driven <= 1'b1;
        repeat (4) @(negedge clk_sys_i);
        note(16'h000F, instr);
        tm.set_trst(1'b1);
        $display("test asynchronous reset done");
        repeat (4) @(posedge clk_sys_i);
        finish_test();
    end
endmodule

//--- testbench/jtag_tester_model.sv
`timescale 1ns/1ps
module jtag_tester_model (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic trst_n_o,
    input wire logic tdo_i
);
    // Test clock only runs inside a frame, so a hang shows as a still clock
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        trst_n_o = 1'b0;
    end
    task automatic set_trst(input logic v);
        trst_n_o = v;
    endtask
    // Change after the falling edge, read the serial output before the rising one
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #80;
        tdo = tdo_i;
        tck_o = 1'b1;
        #80;
        tck_o = 1'b0;
    endtask
    task automatic tlr();
        logic b;
        repeat (6) step(1'b1, ~tdi_o, b);
        step(1'b0, ~tdi_o, b);
    endtask
    // Idle to idle; data line toggles outside shifting so stale values never pass
    task automatic scan(input logic ir, input int n, input logic [331:0] din,
                        output logic [331:0] dout);
        logic b;
        dout = '0;
        step(1'b1, ~tdi_o, b);
        if (ir) step(1'b1, ~tdi_o, b);
        step(1'b0, ~tdi_o, b);
        step(1'b0, ~tdi_o, b);
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
        step(1'b1, ~tdi_o, b);
        step(1'b0, ~tdi_o, b);
    endtask
endmodule
